/* File: gce_consts.svh */
`ifndef GCE_CONSTS_SVH
`define GCE_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GCE_OFF_CTRL 8'h00
`define GCE_OFF_CMD 8'h04
`define GCE_OFF_PAY0 8'h08
`define GCE_OFF_PAY1 8'h0c
`define GCE_OFF_STAT 8'h10
`define GCE_OFF_REPLY 8'h14
`define GCE_OFF_DATA 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GCE_CTRL_USB 0
`define GCE_OPT_MANUAL 0
`define GCE_OPT_GAMMA 1
`define GCE_IMG_TRANSP 0
`define GCE_IMG_INV 1
`define GCE_IMG_RLE 2
`define GCE_STAT_BUSY 0
`define GCE_STAT_RVLD 1
`define GCE_STAT_MANUAL 2
`define GCE_STAT_GAMMA 3

// ----------------------------------------
// Packet codes and values
// ----------------------------------------
`define GCE_CMD_TYPE 8'h28
`define GCE_ACK_BIT 8'h40
`define GCE_ERR_TYPE 8'he8
`define GCE_RLE_MARK 8'h03
`define GCE_PIX_MASK 8'hf8
`define GCE_SC_OPT 8'h00
`define GCE_SC_FLUSH 8'h01
`define GCE_SC_STREAM 8'h02
`define GCE_SC_CARD 8'h03
`define GCE_SC_SHOT 8'h04
`define GCE_SC_PIXEL 8'h05
`define GCE_SC_LINE 8'h06
`define GCE_SC_RECT 8'h07
`define GCE_SC_CIRCLE 8'h08

// ----------------------------------------
// Frame and timing
// ----------------------------------------
`define GCE_FRAME_W 244
`define GCE_FRAME_H 68
`define GCE_CLK_HZ 50000000
`define GCE_TO_USB_MS 500
`define GCE_TO_OTH_MS 2000

`endif

/* File: gce_pkg.sv */
`default_nettype none
package gce_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEC, ST_BOX, ST_LINE, ST_PRD, ST_STRM, ST_FLUSH, ST_SHOT
  } gce_state_t;

  typedef struct packed {
    logic [7:0] typ;
    logic [7:0] len;
    logic [7:0] d0;
    logic [7:0] d1;
  } gce_reply_t;
endpackage
`default_nettype wire

/* File: gce_frame_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module gce_frame_mem #(
  parameter int unsigned DW = 8,
  parameter int unsigned DEPTH = 16592,
  parameter int unsigned AW = 15
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  if (DEPTH > 2**AW) $error("gce_frame_mem: depth exceeds address range");

  logic [DW-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Read data held until the next enabled read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (ce && re) begin
      rdata <= mem_q[raddr];
    end
  end
endmodule
`default_nettype wire

/* File: gce_engine.sv */
// Operation
// - Coordinates within 0-243 by 0-67, shades 0-255, frame 244x68.
// - Accepted subcommand acknowledged with type 0x68, echoing the subcommand number.
// - Options byte: bit0 manual update, bit1 gamma correction enable.
// - Gamma applies to all graphics drawn here, never to plain text.
// - Manual mode draws only into the off-screen buffer.
// - Flush copies whole buffer to display; no effect in automatic mode.
// - Raw pixel bytes follow the stream command unchecked, without CRC.
// - Stream acknowledge waits until every pixel has arrived.
// - Stream must finish in 500 ms USB or 2 s else error.
// - Only upper five bits of each raw pixel byte are kept.
// - Stream pixels fill raster order from the given origin.
// - Stream payload: subcommand, options, x, y, width, height.
// - Option bit2 expands marker 0x03, count, value run triples.
// - Bit0 makes zero transparent; bit1 inverts shades and transparency value.
// - Card image draws 8-bit greyscale pixels from given origin; the code keeps only the upper five bits, as for stream.
// - Screenshot writes the current frame out, replacing any old file.
// - Manual mode screenshot and pixel read use the off-screen buffer.
// - Pixel length 4 writes shade; length 3 reads, two-byte reply.
// - Line of given shade from start point to finish point.
// - Rectangle with outline and fill shade; zero fill untouched.
// - Circle by centre and radius, outline and fill; zero fill transparent.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "gce_consts.svh"
module gce_engine #(
  parameter int unsigned FRAME_W = `GCE_FRAME_W,
  parameter int unsigned FRAME_H = `GCE_FRAME_H,
  parameter int unsigned AW = 15,
  parameter int unsigned TO_USB_CYC = (`GCE_CLK_HZ / 1000) * `GCE_TO_USB_MS,
  parameter int unsigned TO_OTH_CYC = (`GCE_CLK_HZ / 1000) * `GCE_TO_OTH_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [AW-1:0] scan_addr,
  output logic [7:0] scan_pix
);
  localparam int unsigned NPIX = FRAME_W * FRAME_H;
  if (FRAME_W > 255 || FRAME_H > 255 || NPIX > 2**AW || TO_USB_CYC < 1 || TO_OTH_CYC < 1)
    $error("gce_engine: unsupported parameters");

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [AW-1:0] pix_addr(input logic [8:0] x, input logic [8:0] y);
    pix_addr = AW'(32'(y) * FRAME_W + 32'(x));
  endfunction

  function automatic logic in_frame(input logic [8:0] x, input logic [8:0] y);
    in_frame = (32'(x) < FRAME_W) && (32'(y) < FRAME_H);
  endfunction

  function automatic logic [7:0] gamma_fix(input logic [7:0] s, input logic en);
    logic [15:0] p;
    p = s * s;
    gamma_fix = en ? p[15:8] : s;
  endfunction

  function automatic logic [19:0] sq(input logic [9:0] d);
    logic [9:0] a;
    a = d[9] ? 10'(-d) : d;
    sq = 20'(a * a);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  gce_pkg::gce_state_t st_q;
  gce_pkg::gce_reply_t rep_q;
  logic rep_vld_q, usb_q, manual_q, gamma_q;
  logic [7:0] typ_q, len_q;
  logic [63:0] pay_q;
  logic [2:0] opt_q;
  logic [8:0] x0_q, y0_q, x1_q, y1_q, xe_q, ye_q, cx_q, cy_q;
  logic [7:0] s1_q, s2_q;
  logic [10:0] lerr_q, ldx_q, ldy_q;
  logic sx_q, sy_q;
  logic [1:0] rle_q;
  logic [7:0] rcnt_q, rval_q;
  logic [31:0] to_q;
  logic [AW-1:0] la_q, lp_q;
  logic pend_q, last_q, shot_vld_q;
  logic [7:0] buf_rdata, op;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic commit, wr_cmd, wr_data, rd_data, mapped, ready_ok;
  logic [31:0] rd_val;

  assign op = pay_q[7:0];
  assign commit = ce && psel && penable && pready;
  // A refused command stays refused even if the engine went idle meanwhile
  assign wr_cmd = commit && pwrite && paddr == `GCE_OFF_CMD && st_q == gce_pkg::ST_IDLE
                  && !pslverr;
  assign wr_data = commit && pwrite && paddr == `GCE_OFF_DATA;
  assign rd_data = commit && !pwrite && paddr == `GCE_OFF_DATA;

  always_comb begin
    mapped = 1'b1;
    ready_ok = 1'b1;
    rd_val = '0;
    unique case (paddr)
      `GCE_OFF_CTRL: rd_val = {31'h0, usb_q};
      `GCE_OFF_CMD: rd_val = {16'h0, len_q, typ_q};
      `GCE_OFF_PAY0: rd_val = pay_q[31:0];
      `GCE_OFF_PAY1: rd_val = pay_q[63:32];
      `GCE_OFF_STAT: rd_val = {28'h0, gamma_q, manual_q, rep_vld_q, st_q != gce_pkg::ST_IDLE};
      `GCE_OFF_REPLY: rd_val = rep_q;
      `GCE_OFF_DATA: begin
        // Back-pressure while a run expands or a screenshot byte is fetched
        if (pwrite) begin
          ready_ok = !(st_q == gce_pkg::ST_STRM && rle_q == 2'd3);
        end else begin
          ready_ok = !(st_q == gce_pkg::ST_SHOT && !shot_vld_q);
          rd_val = (st_q == gce_pkg::ST_SHOT) ? {24'h0, buf_rdata} : '0;
        end
      end
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready && ready_ok;
      prdata <= rd_val;
      // Error only with the answer, never from a parked address
      pslverr <= psel && penable && !pready && ready_ok
                 && (!mapped || (pwrite && paddr == `GCE_OFF_CMD && st_q != gce_pkg::ST_IDLE));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_q <= 1'b0;
      pay_q <= '0;
    end else if (commit && pwrite && !pslverr) begin
      if (paddr == `GCE_OFF_CTRL) usb_q <= pwdata[`GCE_CTRL_USB];
      if (paddr == `GCE_OFF_PAY0 && st_q == gce_pkg::ST_IDLE) pay_q[31:0] <= pwdata;
      if (paddr == `GCE_OFF_PAY1 && st_q == gce_pkg::ST_IDLE) pay_q[63:32] <= pwdata;
    end
  end

  // ----------------------------------------
  // Engine datapath
  // ----------------------------------------
  gce_pkg::gce_state_t dec_nx;
  logic fin_ok, fin_err, draw_we, buf_re, em, last_px, box_edge;
  logic [7:0] fin_len, fin_d1, draw_dat, em_byte, conv;
  logic [AW-1:0] draw_a, buf_ra;
  logic [9:0] ddx, ddy;
  logic [19:0] d2, r2, ri2;

  assign last_px = cx_q == x1_q && cy_q == y1_q;
  assign ddx = 10'(cx_q) - 10'(pay_q[15:8]);
  assign ddy = 10'(cy_q) - 10'(pay_q[23:16]);
  assign d2 = sq(ddx) + sq(ddy);
  assign r2 = sq(10'(pay_q[31:24]));
  assign ri2 = sq(10'(pay_q[31:24]) - 10'd1);
  assign box_edge = cx_q == x0_q || cx_q == xe_q || cy_q == y0_q || cy_q == ye_q;

  always_comb begin
    dec_nx = gce_pkg::ST_IDLE;
    fin_ok = 1'b0;
    fin_err = 1'b0;
    fin_len = 8'd1;
    fin_d1 = 8'h00;
    draw_we = 1'b0;
    draw_a = pix_addr(cx_q, cy_q);
    draw_dat = gamma_fix(s1_q, gamma_q);
    buf_re = 1'b0;
    buf_ra = la_q;
    em = 1'b0;
    em_byte = rval_q;
    conv = 8'h00;
    unique case (st_q)
      gce_pkg::ST_DEC: begin
        if (typ_q != `GCE_CMD_TYPE) begin
          fin_err = 1'b1;
        end else begin
          unique case (op)
            `GCE_SC_OPT: begin
              fin_ok = len_q == 8'd2;
              fin_err = len_q != 8'd2;
            end
            `GCE_SC_FLUSH: begin
              if (len_q != 8'd1) fin_err = 1'b1;
              else if (manual_q) dec_nx = gce_pkg::ST_FLUSH;
              else fin_ok = 1'b1;
            end
            `GCE_SC_STREAM: begin
              if (len_q != 8'd6 || !in_frame(9'(pay_q[23:16]), 9'(pay_q[31:24])))
                fin_err = 1'b1;
              else if (pay_q[39:32] == 8'h00 || pay_q[47:40] == 8'h00) fin_ok = 1'b1;
              else dec_nx = gce_pkg::ST_STRM;
            end
            `GCE_SC_CARD: begin
              if (len_q < 8'd6 || !in_frame(9'(pay_q[23:16]), 9'(pay_q[31:24])))
                fin_err = 1'b1;
              else dec_nx = gce_pkg::ST_STRM;
            end
            `GCE_SC_SHOT: begin
              if (len_q < 8'd2) fin_err = 1'b1;
              else dec_nx = gce_pkg::ST_SHOT;
            end
            `GCE_SC_PIXEL: begin
              buf_ra = pix_addr(9'(pay_q[15:8]), 9'(pay_q[23:16]));
              draw_a = buf_ra;
              draw_dat = gamma_fix(pay_q[31:24], gamma_q);
              if (!in_frame(9'(pay_q[15:8]), 9'(pay_q[23:16]))) begin
                fin_err = 1'b1;
              end else if (len_q == 8'd4) begin
                draw_we = 1'b1;
                fin_ok = 1'b1;
              end else if (len_q == 8'd3) begin
                buf_re = 1'b1;
                dec_nx = gce_pkg::ST_PRD;
              end else begin
                fin_err = 1'b1;
              end
            end
            `GCE_SC_LINE: begin
              if (len_q != 8'd6 || !in_frame(9'(pay_q[15:8]), 9'(pay_q[23:16]))
                  || !in_frame(9'(pay_q[31:24]), 9'(pay_q[39:32])))
                fin_err = 1'b1;
              else dec_nx = gce_pkg::ST_LINE;
            end
            `GCE_SC_RECT: begin
              if (len_q != 8'd7 || !in_frame(9'(pay_q[15:8]), 9'(pay_q[23:16]))
                  || !in_frame(9'(pay_q[31:24]), 9'(pay_q[39:32])))
                fin_err = 1'b1;
              else if (pay_q[31:24] == 8'h00 || pay_q[39:32] == 8'h00) fin_ok = 1'b1;
              else dec_nx = gce_pkg::ST_BOX;
            end
            `GCE_SC_CIRCLE: begin
              if (len_q != 8'd6 || !in_frame(9'(pay_q[15:8]), 9'(pay_q[23:16])))
                fin_err = 1'b1;
              else dec_nx = gce_pkg::ST_BOX;
            end
            default: fin_err = 1'b1;
          endcase
        end
      end
      gce_pkg::ST_BOX: begin
        if (op == `GCE_SC_RECT) begin
          draw_we = box_edge || s2_q != 8'h00;
          draw_dat = gamma_fix(box_edge ? s1_q : s2_q, gamma_q);
        end else begin
          draw_we = (d2 <= r2 && (pay_q[31:24] == 8'h00 || d2 > ri2))
                    || (d2 <= ri2 && pay_q[31:24] != 8'h00 && s2_q != 8'h00);
          draw_dat = gamma_fix((d2 <= ri2 && pay_q[31:24] != 8'h00) ? s2_q : s1_q, gamma_q);
        end
        fin_ok = last_px;
      end
      gce_pkg::ST_LINE: begin
        draw_we = 1'b1;
        fin_ok = last_px;
      end
      gce_pkg::ST_PRD: begin
        fin_ok = 1'b1;
        fin_len = 8'd2;
        fin_d1 = buf_rdata;
      end
      gce_pkg::ST_STRM: begin
        // Raw bytes are taken as they come, with no integrity check
        if (rle_q == 2'd3) begin
          em = rcnt_q != 8'h00;
        end else if (wr_data) begin
          em_byte = pwdata[7:0];
          em = !(op == `GCE_SC_STREAM && opt_q[`GCE_IMG_RLE])
               || (rle_q == 2'd0 && pwdata[7:0] != `GCE_RLE_MARK);
        end
        conv = em_byte & `GCE_PIX_MASK;
        if (opt_q[`GCE_IMG_INV]) conv = ~conv & `GCE_PIX_MASK;
        draw_dat = gamma_fix(conv, gamma_q);
        draw_we = em && in_frame(cx_q, cy_q) && !(opt_q[`GCE_IMG_TRANSP] && conv == 8'h00);
        fin_ok = em && last_px;
        fin_err = !fin_ok && to_q == (usb_q ? TO_USB_CYC - 1 : TO_OTH_CYC - 1);
      end
      gce_pkg::ST_FLUSH: begin
        buf_re = !last_q;
        fin_ok = last_q;
      end
      gce_pkg::ST_SHOT: begin
        buf_re = !shot_vld_q && !pend_q;
        fin_ok = rd_data && la_q == AW'(NPIX - 1);
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------
  // Frame stores
  // ----------------------------------------
  logic disp_we;
  logic [AW-1:0] disp_wa;
  logic [7:0] disp_wd;
  logic flush_wr;

  assign flush_wr = st_q == gce_pkg::ST_FLUSH && pend_q;
  assign disp_we = flush_wr || (draw_we && !manual_q);
  assign disp_wa = flush_wr ? lp_q : draw_a;
  assign disp_wd = flush_wr ? buf_rdata : draw_dat;

  gce_frame_mem #(.DW(8), .DEPTH(NPIX), .AW(AW)) u_buf (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .we(draw_we),
    .waddr(draw_a),
    .wdata(draw_dat),
    .re(buf_re),
    .raddr(buf_ra),
    .rdata(buf_rdata)
  );

  gce_frame_mem #(.DW(8), .DEPTH(NPIX), .AW(AW)) u_disp (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .we(disp_we),
    .waddr(disp_wa),
    .wdata(disp_wd),
    .re(1'b1),
    .raddr(scan_addr),
    .rdata(scan_pix)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= gce_pkg::ST_IDLE;
      rep_q <= '0;
      rep_vld_q <= 1'b0;
      typ_q <= '0;
      len_q <= '0;
      manual_q <= 1'b0;
      gamma_q <= 1'b0;
    end else if (ce) begin
      if (fin_ok || fin_err) begin
        rep_q.typ <= fin_ok ? (typ_q | `GCE_ACK_BIT) : `GCE_ERR_TYPE;
        rep_q.len <= fin_ok ? fin_len : 8'd1;
        rep_q.d0 <= op;
        rep_q.d1 <= fin_ok ? fin_d1 : 8'h00;
        rep_vld_q <= 1'b1;
        st_q <= gce_pkg::ST_IDLE;
      end else if (st_q == gce_pkg::ST_DEC) begin
        st_q <= dec_nx;
      end
      if (wr_cmd) begin
        typ_q <= pwdata[7:0];
        len_q <= pwdata[15:8];
        rep_vld_q <= 1'b0;
        st_q <= gce_pkg::ST_DEC;
      end
      if (fin_ok && st_q == gce_pkg::ST_DEC && op == `GCE_SC_OPT) begin
        manual_q <= pay_q[8 + `GCE_OPT_MANUAL];
        gamma_q <= pay_q[8 + `GCE_OPT_GAMMA];
      end
    end
  end

  // Walk set-up and pixel stepping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {x0_q, y0_q, x1_q, y1_q, xe_q, ye_q, cx_q, cy_q} <= '0;
      {s1_q, s2_q, opt_q} <= '0;
      {lerr_q, ldx_q, ldy_q, sx_q, sy_q} <= '0;
    end else if (ce && st_q == gce_pkg::ST_DEC) begin
      opt_q <= pay_q[10:8];
      s1_q <= op == `GCE_SC_LINE ? pay_q[47:40] : (op == `GCE_SC_RECT ? pay_q[47:40] : pay_q[39:32]);
      s2_q <= op == `GCE_SC_RECT ? pay_q[55:48] : pay_q[47:40];
      if (op == `GCE_SC_STREAM || op == `GCE_SC_CARD) begin
        x0_q <= 9'(pay_q[23:16]);
        y0_q <= 9'(pay_q[31:24]);
        x1_q <= op == `GCE_SC_CARD ? 9'(FRAME_W - 1) : 9'(pay_q[23:16]) + 9'(pay_q[39:32]) - 9'd1;
        y1_q <= op == `GCE_SC_CARD ? 9'(FRAME_H - 1) : 9'(pay_q[31:24]) + 9'(pay_q[47:40]) - 9'd1;
        cx_q <= 9'(pay_q[23:16]);
        cy_q <= 9'(pay_q[31:24]);
      end else if (op == `GCE_SC_CIRCLE) begin
        x0_q <= pay_q[15:8] > pay_q[31:24] ? 9'(pay_q[15:8] - pay_q[31:24]) : 9'd0;
        y0_q <= pay_q[23:16] > pay_q[31:24] ? 9'(pay_q[23:16] - pay_q[31:24]) : 9'd0;
        cx_q <= pay_q[15:8] > pay_q[31:24] ? 9'(pay_q[15:8] - pay_q[31:24]) : 9'd0;
        cy_q <= pay_q[23:16] > pay_q[31:24] ? 9'(pay_q[23:16] - pay_q[31:24]) : 9'd0;
        x1_q <= 9'(FRAME_W - 1) < 9'(pay_q[15:8]) + 9'(pay_q[31:24]) ? 9'(FRAME_W - 1)
                : 9'(pay_q[15:8]) + 9'(pay_q[31:24]);
        y1_q <= 9'(FRAME_H - 1) < 9'(pay_q[23:16]) + 9'(pay_q[31:24]) ? 9'(FRAME_H - 1)
                : 9'(pay_q[23:16]) + 9'(pay_q[31:24]);
      end else begin
        x0_q <= 9'(pay_q[15:8]);
        y0_q <= 9'(pay_q[23:16]);
        cx_q <= 9'(pay_q[15:8]);
        cy_q <= 9'(pay_q[23:16]);
        xe_q <= 9'(pay_q[15:8]) + 9'(pay_q[31:24]) - 9'd1;
        ye_q <= 9'(pay_q[23:16]) + 9'(pay_q[39:32]) - 9'd1;
        // Rectangle clipped to the frame; line end is its finish point
        x1_q <= op == `GCE_SC_LINE ? 9'(pay_q[31:24])
                : (9'(pay_q[15:8]) + 9'(pay_q[31:24]) > 9'(FRAME_W) ? 9'(FRAME_W - 1)
                : 9'(pay_q[15:8]) + 9'(pay_q[31:24]) - 9'd1);
        y1_q <= op == `GCE_SC_LINE ? 9'(pay_q[39:32])
                : (9'(pay_q[23:16]) + 9'(pay_q[39:32]) > 9'(FRAME_H) ? 9'(FRAME_H - 1)
                : 9'(pay_q[23:16]) + 9'(pay_q[39:32]) - 9'd1);
        sx_q <= pay_q[31:24] < pay_q[15:8];
        sy_q <= pay_q[39:32] < pay_q[23:16];
        ldx_q <= pay_q[31:24] < pay_q[15:8] ? 11'(pay_q[15:8] - pay_q[31:24])
                 : 11'(pay_q[31:24] - pay_q[15:8]);
        ldy_q <= pay_q[39:32] < pay_q[23:16] ? 11'(pay_q[39:32]) - 11'(pay_q[23:16])
                 : 11'(pay_q[23:16]) - 11'(pay_q[39:32]);
        lerr_q <= (pay_q[31:24] < pay_q[15:8] ? 11'(pay_q[15:8] - pay_q[31:24])
                  : 11'(pay_q[31:24] - pay_q[15:8]))
                  + (pay_q[39:32] < pay_q[23:16] ? 11'(pay_q[39:32]) - 11'(pay_q[23:16])
                  : 11'(pay_q[23:16]) - 11'(pay_q[39:32]));
      end
    end else if (ce && st_q == gce_pkg::ST_LINE && !last_px) begin
      // Bresenham step, both axes may move in one cycle
      if ($signed({lerr_q, 1'b0}) >= $signed({ldy_q[10], ldy_q})) begin
        cx_q <= sx_q ? cx_q - 9'd1 : cx_q + 9'd1;
      end
      if ($signed({lerr_q, 1'b0}) <= $signed({1'b0, ldx_q})) begin
        cy_q <= sy_q ? cy_q - 9'd1 : cy_q + 9'd1;
      end
      lerr_q <= lerr_q
                + ($signed({lerr_q, 1'b0}) >= $signed({ldy_q[10], ldy_q}) ? ldy_q : 11'd0)
                + ($signed({lerr_q, 1'b0}) <= $signed({1'b0, ldx_q}) ? ldx_q : 11'd0);
    end else if (ce && (st_q == gce_pkg::ST_BOX || em) && !last_px) begin
      if (cx_q == x1_q) begin
        cx_q <= x0_q;
        cy_q <= cy_q + 9'd1;
      end else begin
        cx_q <= cx_q + 9'd1;
      end
    end
  end

  // Stream decoding, timeout, flush and screenshot pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rle_q, rcnt_q, rval_q, to_q} <= '0;
      {la_q, lp_q, pend_q, last_q, shot_vld_q} <= '0;
    end else if (ce) begin
      if (st_q == gce_pkg::ST_DEC) begin
        {rle_q, to_q, la_q, pend_q, last_q, shot_vld_q} <= '0;
      end else if (st_q == gce_pkg::ST_STRM) begin
        to_q <= to_q + 32'd1;
        if (rle_q == 2'd3) begin
          if (rcnt_q != 8'h00) rcnt_q <= rcnt_q - 8'd1;
          else rle_q <= 2'd0;
        end else if (wr_data && op == `GCE_SC_STREAM && opt_q[`GCE_IMG_RLE]) begin
          unique case (rle_q)
            2'd0: if (pwdata[7:0] == `GCE_RLE_MARK) rle_q <= 2'd1;
            2'd1: begin
              rcnt_q <= pwdata[7:0];
              rle_q <= 2'd2;
            end
            default: begin
              rval_q <= pwdata[7:0];
              rle_q <= 2'd3;
            end
          endcase
        end
      end else if (st_q == gce_pkg::ST_FLUSH && !last_q) begin
        lp_q <= la_q;
        pend_q <= 1'b1;
        if (la_q == AW'(NPIX - 1)) last_q <= 1'b1;
        else la_q <= la_q + AW'(1);
      end else if (st_q == gce_pkg::ST_SHOT) begin
        if (buf_re) pend_q <= 1'b1;
        if (pend_q) begin
          pend_q <= 1'b0;
          shot_vld_q <= 1'b1;
        end
        if (rd_data) begin
          shot_vld_q <= 1'b0;
          la_q <= la_q + AW'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: gce_engine_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------
// Bus and reply checks
// ------------------------
module gce_engine_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] scan_pix
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY_PULSE: assert property (pready && ce |=> !pready)
    else $error("pready held past one cycle");
  AST_RDY_CAUSE: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("pready without access phase");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UNMAPPED: assert property ((ce && psel && penable && !pready && paddr > 8'h18) ##1 ce
    |-> pready && pslverr)
    else $error("unmapped access not refused");
  AST_REG_ANSWER: assert property ((ce && psel && penable && !pready && paddr != 8'h18) ##1 ce
    |-> pready)
    else $error("register access late");
  AST_REPLY_TYPE: assert property (pready && !pwrite && paddr == 8'h14
    |-> prdata[31:24] inside {8'h00, 8'h68, 8'he8})
    else $error("bad reply type");
  AST_MAPPED_ERR: assert property (pready && pslverr && paddr <= 8'h18
    |-> pwrite && paddr == 8'h04)
    else $error("mapped access refused");
  // Clock enable low must hold pready and scan_pix
  AST_FREEZE: assert property (!ce |=> $stable(pready) && $stable(scan_pix))
    else $error("state moved while frozen");
endmodule
bind gce_engine gce_engine_assertions u_gce_engine_assertions (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scan_pix(scan_pix));
`default_nettype wire

/* File: gce_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------
// Host side bus master
// ------------------------
module gce_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // Waits unbounded; the bench timeout cuts a hang
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, scan_pix;
  logic [31:0] pwdata, prdata, q;
  logic [14:0] scan_addr = 15'h0000;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  always #10 pclk = ~pclk;
  // Short timeouts keep the stream abort quick
  gce_engine #(.TO_USB_CYC(200), .TO_OTH_CYC(400)) u_gce_engine (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_addr(scan_addr),
    .scan_pix(scan_pix));
  gce_host_model u_gce_host_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  task test_done();
    $display("failures=%0d compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      test_done();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_gce_host_model.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [7:0] a);
    u_gce_host_model.xfer(1'b0, a, 32'h00000000, q, e);
  endtask
  task send(input logic [7:0] ln, input logic [31:0] p0, input logic [31:0] p1);
    wr(8'h08, p0);
    wr(8'h0c, p1);
    wr(8'h04, {16'h0000, ln, 8'h28});
  endtask
  task fin(input logic [7:0] ty, input logic [7:0] sb);
    do rd(8'h10); while (q[1] !== 1'b1);
    rd(8'h14);
    chk(q[31:24], ty);
    chk(q[15:8], sb);
  endtask
  task scan(input int a, input logic [7:0] x);
    @(posedge pclk);
    scan_addr <= a[14:0];
    repeat (2) @(posedge pclk);
    #1 chk(scan_pix, x);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    send(8'h02, 32'h00000000, 0);
    fin(8'h68, 8'h00);
    send(8'h04, 32'h5b43f305, 0);
    fin(8'h68, 8'h05);
    send(8'h03, 32'h0043f305, 0);
    fin(8'h68, 8'h05);
    chk(q[23:0], 24'h02055b);
    scan(16591, 8'h5b);
    // Freeze only once the scanned pixel holds a known value
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    $display("test pixel done");
    send(8'h04, 32'h40000005, 0);
    fin(8'h68, 8'h05);
    send(8'h02, 32'h00000100, 0);
    fin(8'h68, 8'h00);
    rd(8'h10);
    chk(q[2], 1'b1);
    send(8'h04, 32'h80000005, 0);
    fin(8'h68, 8'h05);
    scan(0, 8'h40);
    send(8'h03, 32'h00000005, 0);
    fin(8'h68, 8'h05);
    chk(q[7:0], 8'h80);
    send(8'h01, 32'h00000001, 0);
    fin(8'h68, 8'h01);
    scan(0, 8'h80);
    send(8'h02, 32'h00000200, 0);
    fin(8'h68, 8'h00);
    send(8'h07, 32'h03021407, 32'h00208003);
    fin(8'h68, 8'h07);
    scan(508, 8'h40);
    scan(753, 8'h04);
    send(8'h06, 32'h21011e06, 32'h00008001);
    fin(8'h68, 8'h06);
    scan(276, 8'h40);
    send(8'h02, 32'h00000000, 0);
    fin(8'h68, 8'h00);
    $display("test manual done");
    send(8'h04, 32'h1000f405, 0);
    fin(8'he8, 8'h05);
    send(8'h01, 32'h00000009, 0);
    fin(8'he8, 8'h09);
    rd(8'h40);
    chk(e, 1'b1);
    $display("test error done");
    send(8'h06, 32'h050a0402, 32'h00000103);
    wr(8'h18, 32'h00000003);
    wr(8'h18, 32'h00000002);
    wr(8'h18, 32'h00000047);
    rd(8'h10);
    chk(q[1], 1'b0);
    wr(8'h18, 32'h00000033);
    fin(8'h68, 8'h02);
    scan(1231, 8'h40);
    scan(1232, 8'h30);
    send(8'h06, 32'h050a0302, 32'h00000102);
    wr(8'h18, 32'h000000ff);
    wr(8'h18, 32'h0000000f);
    fin(8'h68, 8'h02);
    scan(1230, 8'h40);
    scan(1231, 8'hf0);
    wr(8'h00, 32'h00000001);
    send(8'h06, 32'h050a0002, 32'h00000101);
    fin(8'he8, 8'h02);
    wr(8'h18, 32'h00000055);
    scan(1230, 8'h40);
    $display("test stream done");
    test_done();
  end
endmodule
`default_nettype wire
